// >>> rtl/usb_regs_pkg.sv
package usb_regs_pkg;

  // register offsets: memory space and configuration space
  localparam logic [7:0] OFS_REVISION = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_CMD_STATUS = 8'h08;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h0C;
  localparam logic [7:0] OFS_EVT_EN_SET = 8'h10;
  localparam logic [7:0] OFS_EVT_EN_CLR = 8'h14;
  localparam logic [7:0] OFS_TEST_CTRL = 8'h40;
  localparam logic [7:0] OFS_OP_MODE = 8'h44;

  localparam logic [31:0] REVISION_VALUE = 32'h0000_0110;

  // control register fields
  localparam int CTL_IRQ_DEST = 8;
  localparam int CTL_STATE_LO = 6;
  localparam int CTL_BULK_ON = 5;
  localparam int CTL_CTRL_ON = 4;
  localparam int CTL_ISO_ON = 3;
  localparam int CTL_PERIODIC_ON = 2;
  localparam int CTL_RATIO_LO = 0;

  // command/status fields
  localparam int CMD_TALLY_LO = 16;
  localparam int CMD_OWNER_REQ = 3;
  localparam int CMD_BULK_PEND = 2;
  localparam int CMD_CTRL_PEND = 1;
  localparam int CMD_SOFT_RESET = 0;

  // event status / enable bit positions
  localparam int EV_GATE = 31;
  localparam int EV_OWNER = 30;
  localparam int EV_HUB = 6;
  localparam int EV_WRAP = 5;
  localparam int EV_FATAL = 4;
  localparam int EV_RESUME = 3;
  localparam int EV_SOF = 2;
  localparam int EV_DONE = 1;
  localparam int EV_OVERRUN = 0;
  localparam logic [31:0] EVT_IMPL_MASK = 32'h4000_006F;
  localparam logic [31:0] EN_IMPL_MASK = 32'hC000_006F;

  // engine test register fields
  localparam int TST_CODE_LO = 16;
  localparam int TST_TOGGLE = 15;
  localparam int TST_SPEED = 14;
  localparam int TST_FORMAT = 13;
  localparam int TST_DIR_LO = 11;
  localparam int TST_ADDR_LO = 0;

  // operational mode fields
  localparam int OM_OVERLAP_OFF = 8;
  localparam int OM_SMALL_BUF = 0;
  localparam logic [5:0] BUF_SMALL_BYTES = 6'h10;
  localparam logic [5:0] BUF_LARGE_BYTES = 6'h20;

  // software reset duration
  localparam int CLK_PERIOD_NS = 4;
  localparam int SOFT_RESET_NS = 100;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    STATE_RESET = 2'b00,
    STATE_RESUME = 2'b01,
    STATE_OPERATIONAL = 2'b10,
    STATE_SUSPEND = 2'b11
  } hc_state_e;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_BUSY = 2'b10
  } seq_state_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic cfg_space;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } bus_req_s;

  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } bus_rsp_s;

  typedef struct packed {
    logic [3:0] txn_completion_code;
    logic frame_counter_msb;
    logic hub_change;
    logic resume_seen;
    logic frame_start;
    logic done_list_posted;
    logic schedule_overrun;
    logic bulk_head_begin;
    logic ctrl_head_begin;
    logic bulk_fill_set;
    logic ctrl_fill_set;
    logic engine_status_ready;
    logic usb_bus_busy;
  } partner_in_s;

  typedef struct packed {
    logic test_data_toggle;
    logic test_endpoint_speed;
    logic test_endpoint_format;
    logic [1:0] test_txn_direction;
    logic [10:0] test_endpoint_address;
  } test_fields_s;

  typedef struct packed {
    hc_state_e controller_state_field;
    logic bulk_walk_on;
    logic ctrl_walk_on;
    logic iso_walk_on;
    logic periodic_walk_on;
    logic [1:0] ctrl_per_bulk_ratio;
    logic bulk_pending;
    logic ctrl_pending;
    logic engine_overlap_off;
    logic [5:0] buffer_region_bytes;
    logic completion_to_lp;
    logic soft_reset_active;
    logic irq_int;
    logic irq_smi;
  } ctrl_out_s;

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    merge_be = (old_v & ~be_mask(be)) | (new_v & be_mask(be));
  endfunction : merge_be

endpackage : usb_regs_pkg

// >>> rtl/event_bank.sv
`timescale 1ns/1ps
module event_bank
  import usb_regs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // hardware event pulses, one bit per status position
  input wire logic [31:0] set_evt,
  // software writes, data already masked by byte enables
  input wire logic clr_wr,
  input wire logic en_set_wr,
  input wire logic en_clr_wr,
  input wire logic [31:0] wmasked,
  // register contents
  output logic [31:0] status,
  output logic [31:0] enable
);
  typedef struct packed {
    logic [31:0] status;
    logic [31:0] enable;
  } bank_state_s;

  bank_state_s st_r;
  bank_state_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    // a set arriving with the clearing write wins
    st_nxt.status = ((st_r.status & ~(clr_wr ? wmasked : 32'h0000_0000)) | set_evt)
                    & EVT_IMPL_MASK; // see [RQ18] see [RQ24] see [RQ20]
    st_nxt.enable = ((st_r.enable | (en_set_wr ? wmasked : 32'h0000_0000))
                    & ~(en_clr_wr ? wmasked : 32'h0000_0000))
                    & EN_IMPL_MASK; // see [RQ21] see [RQ22]
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign status = st_r.status;
  assign enable = st_r.enable;

  a_fatal_stays_zero: assert property (@(posedge clk) disable iff (!rst_b)
    !status[EV_FATAL] && !enable[EV_FATAL]) else $error("fatal error bit not zero"); // see [RQ20]
  a_enable_set_w1: assert property (@(posedge clk) disable iff (!rst_b)
    en_set_wr && wmasked[EV_SOF] |=> enable[EV_SOF]) else $error("enable set ignored"); // see [RQ21]
  a_status_zero_keeps: assert property (@(posedge clk) disable iff (!rst_b)
    clr_wr && !wmasked[EV_HUB] && status[EV_HUB] |=> status[EV_HUB])
    else $error("status lost on zero write"); // see [RQ24]

endmodule : event_bank

// >>> rtl/soft_reset_seq.sv
`timescale 1ns/1ps
module soft_reset_seq
  import usb_regs_pkg::*;
#(
  parameter int RESET_CYCLES = SOFT_RESET_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);
  typedef struct packed {
    seq_state_e fsm;
    logic [15:0] count;
    logic done;
  } seq_state_s;

  seq_state_s st_r;
  seq_state_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    case (st_r.fsm)
      SEQ_IDLE:
      begin
        if (start)
        begin
          st_nxt.fsm = SEQ_BUSY;
          st_nxt.count = 16'(RESET_CYCLES - 1);
        end
      end
      SEQ_BUSY:
      begin
        if (st_r.count == 16'h0000)
        begin
          st_nxt.fsm = SEQ_IDLE;
          st_nxt.done = 1'b1;
        end
        else
          st_nxt.count = st_r.count - 16'h0001;
      end
      default:
        st_nxt.fsm = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r.fsm <= SEQ_IDLE;
      st_r.count <= 16'h0000;
      st_r.done <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  assign busy = (st_r.fsm == SEQ_BUSY);
  assign done = st_r.done;

endmodule : soft_reset_seq

// >>> rtl/usb_host_op_regs.sv
// What this block does
// [RQ1] test register bits 19-16 show completion code
// [RQ2] test mode fields written at bits 15-0
// [RQ3] write-only bits always read back zero
// [RQ4] overlap off holds completion until bus idle
// [RQ5] buffer region 16 bytes if set, else 32
// [RQ6] revision register reads constant 00000110h
// [RQ7] control bit 8 routes interrupt to smi
// [RQ8] control bits 7-6 hold written controller state
// [RQ9] suspend moves to resume on resume signalling
// [RQ10] bulk and control list enables gate walking
// [RQ11] iso bit clear skips isochronous descriptors only
// [RQ12] periodic enable sampled at each frame start
// [RQ13] bits 1-0 set control per bulk ratio
// [RQ14] overrun tally counts overruns, wraps at four
// [RQ15] owner request write sets owner swap status
// [RQ16] list pending bits cleared at head processing
// [RQ17] soft reset bit self-clears after reset completes
// [RQ18] status bits set by hardware, cleared by software
// [RQ19] listed events set their status bits
// [RQ20] fatal error bit reads zero, writes ignored
// [RQ21] enable set/clear registers write one to act
// [RQ22] enable bit 31 gates every interrupt
// [RQ23] interrupt raised when status, enable, gate agree
// [RQ24] writing one clears a status bit
`timescale 1ns/1ps
module usb_host_op_regs
  import usb_regs_pkg::*;
#(
  parameter int RESET_CYCLES = usb_regs_pkg::SOFT_RESET_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register access from the bus interface unit
  input wire usb_regs_pkg::bus_req_s bus_req,
  output usb_regs_pkg::bus_rsp_s bus_rsp,
  // partner blocks: list processor, frame management, serial engine
  input wire usb_regs_pkg::partner_in_s partner,
  // controls and interrupt lines
  output usb_regs_pkg::ctrl_out_s ctrl,
  output usb_regs_pkg::test_fields_s test_fields
);
  import usb_regs_pkg::*;

  typedef struct packed {
    logic irq_dest;
    hc_state_e hc_state;
    logic bulk_on;
    logic ctrl_on;
    logic iso_on;
    logic periodic_on;
    logic periodic_go;
    logic [1:0] ratio;
    logic [1:0] tally;
    logic owner_req;
    logic bulk_pend;
    logic ctrl_pend;
    logic reset_cmd;
    logic overlap_off;
    logic small_buf;
    logic [5:0] buf_bytes;
    test_fields_s test;
    logic frame_msb_q;
    logic completion;
    logic irq_int;
    logic irq_smi;
    bus_rsp_s rsp;
  } top_state_s;

  top_state_s st_r;
  top_state_s st_nxt;

  logic [31:0] evt_status;
  logic [31:0] evt_enable;
  logic [31:0] set_evt;
  logic [31:0] wmasked;
  logic seq_busy;
  logic seq_done;
  logic seq_start;
  logic wr_mem;
  logic wr_cfg;
  logic rd_any;
  logic wr_ctl;
  logic wr_cmd;
  logic irq_pending;
  logic [31:0] ctl_word;
  logic [31:0] ctl_new;
  logic [31:0] tst_new;
  logic [31:0] om_new;
  logic [31:0] addr_merge;

  assign wr_mem = bus_req.valid && bus_req.write && !bus_req.cfg_space;
  assign wr_cfg = bus_req.valid && bus_req.write && bus_req.cfg_space;
  assign rd_any = bus_req.valid && !bus_req.write;
  assign wr_ctl = wr_mem && (bus_req.addr == OFS_CONTROL);
  assign wr_cmd = wr_mem && (bus_req.addr == OFS_CMD_STATUS);
  assign wmasked = bus_req.wdata & be_mask(bus_req.be);

  // control register as software sees it
  always_comb
  begin
    ctl_word = 32'h0000_0000;
    ctl_word[CTL_IRQ_DEST] = st_r.irq_dest;
    ctl_word[CTL_STATE_LO +: 2] = st_r.hc_state;
    ctl_word[CTL_BULK_ON] = st_r.bulk_on;
    ctl_word[CTL_CTRL_ON] = st_r.ctrl_on;
    ctl_word[CTL_ISO_ON] = st_r.iso_on;
    ctl_word[CTL_PERIODIC_ON] = st_r.periodic_on;
    ctl_word[CTL_RATIO_LO +: 2] = st_r.ratio;
  end

  assign ctl_new = merge_be(ctl_word, bus_req.wdata, bus_req.be);
  assign tst_new = merge_be(32'h0000_0000, bus_req.wdata, bus_req.be);
  assign om_new = merge_be({23'h000000, st_r.overlap_off, 7'h00, st_r.small_buf},
                           bus_req.wdata, bus_req.be);
  // address straddles two byte lanes: a single-lane write keeps the other lane
  assign addr_merge = merge_be({21'h000000, st_r.test.test_endpoint_address},
                               bus_req.wdata, bus_req.be);

  // hardware events into the status bank
  always_comb
  begin
    set_evt = 32'h0000_0000;
    // a write of one to the owner request raises the event once per write
    set_evt[EV_OWNER] = wr_cmd && wmasked[CMD_OWNER_REQ]; // see [RQ15]
    set_evt[EV_HUB] = partner.hub_change; // see [RQ19]
    set_evt[EV_WRAP] = partner.frame_counter_msb != st_r.frame_msb_q; // see [RQ19]
    set_evt[EV_RESUME] = partner.resume_seen; // see [RQ19]
    set_evt[EV_SOF] = partner.frame_start; // see [RQ19]
    set_evt[EV_DONE] = partner.done_list_posted; // see [RQ19]
    set_evt[EV_OVERRUN] = partner.schedule_overrun; // see [RQ19]
  end

  // only software writing one to an idle bit starts a reset
  assign seq_start = wr_cmd && wmasked[CMD_SOFT_RESET] && !st_r.reset_cmd;

  assign irq_pending = evt_enable[EV_GATE]
                       && (|(evt_status & evt_enable & EVT_IMPL_MASK)); // see [RQ22] see [RQ23]

  event_bank u_event_bank (
    .clk(clk),
    .rst_b(rst_b),
    .set_evt(set_evt),
    .clr_wr(wr_mem && (bus_req.addr == OFS_EVT_STATUS)),
    .en_set_wr(wr_mem && (bus_req.addr == OFS_EVT_EN_SET)),
    .en_clr_wr(wr_mem && (bus_req.addr == OFS_EVT_EN_CLR)),
    .wmasked(wmasked),
    .status(evt_status),
    .enable(evt_enable)
  );

  soft_reset_seq #(
    .RESET_CYCLES(RESET_CYCLES)
  ) u_soft_reset_seq (
    .clk(clk),
    .rst_b(rst_b),
    .start(seq_start),
    .busy(seq_busy),
    .done(seq_done)
  );

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.frame_msb_q = partner.frame_counter_msb;

    // control register
    if (wr_ctl)
    begin
      st_nxt.irq_dest = ctl_new[CTL_IRQ_DEST]; // see [RQ7]
      st_nxt.hc_state = hc_state_e'(ctl_new[CTL_STATE_LO +: 2]); // see [RQ8]
      st_nxt.bulk_on = ctl_new[CTL_BULK_ON]; // see [RQ10]
      st_nxt.ctrl_on = ctl_new[CTL_CTRL_ON]; // see [RQ10]
      st_nxt.iso_on = ctl_new[CTL_ISO_ON]; // see [RQ11]
      st_nxt.periodic_on = ctl_new[CTL_PERIODIC_ON];
      st_nxt.ratio = ctl_new[CTL_RATIO_LO +: 2]; // see [RQ13]
    end
    else if (st_r.hc_state == STATE_SUSPEND && partner.resume_seen)
      st_nxt.hc_state = STATE_RESUME; // see [RQ9]

    // periodic enable takes effect only at a frame boundary
    if (partner.frame_start)
      st_nxt.periodic_go = st_r.periodic_on; // see [RQ12]

    // command/status register
    if (partner.schedule_overrun)
      st_nxt.tally = st_r.tally + 2'b01; // see [RQ14]
    if (wr_cmd && bus_req.be[0])
      st_nxt.owner_req = bus_req.wdata[CMD_OWNER_REQ]; // see [RQ15]
    // head processing clears, any set in the same cycle wins
    if (partner.bulk_head_begin)
      st_nxt.bulk_pend = 1'b0;
    if (partner.ctrl_head_begin)
      st_nxt.ctrl_pend = 1'b0;
    if (partner.bulk_fill_set || (wr_cmd && wmasked[CMD_BULK_PEND]))
      st_nxt.bulk_pend = 1'b1; // see [RQ16]
    if (partner.ctrl_fill_set || (wr_cmd && wmasked[CMD_CTRL_PEND]))
      st_nxt.ctrl_pend = 1'b1; // see [RQ16]
    if (seq_start)
      st_nxt.reset_cmd = 1'b1;
    if (seq_done)
    begin
      // reset leaves the controller suspended with lists off
      st_nxt.reset_cmd = 1'b0; // see [RQ17]
      st_nxt.hc_state = STATE_SUSPEND;
      st_nxt.bulk_on = 1'b0;
      st_nxt.ctrl_on = 1'b0;
      st_nxt.iso_on = 1'b0;
      st_nxt.periodic_on = 1'b0;
      st_nxt.periodic_go = 1'b0;
      st_nxt.bulk_pend = 1'b0;
      st_nxt.ctrl_pend = 1'b0;
    end

    // configuration space
    if (wr_cfg && bus_req.addr == OFS_TEST_CTRL)
    begin
      st_nxt.test.test_data_toggle = tst_new[TST_TOGGLE]; // see [RQ2]
      st_nxt.test.test_endpoint_speed = tst_new[TST_SPEED];
      st_nxt.test.test_endpoint_format = tst_new[TST_FORMAT];
      if (bus_req.be[1])
        st_nxt.test.test_txn_direction = tst_new[TST_DIR_LO +: 2];
      if (bus_req.be[1] || bus_req.be[0])
        st_nxt.test.test_endpoint_address = tst_new[TST_ADDR_LO +: 11];
      if (!bus_req.be[1])
      begin
        st_nxt.test.test_data_toggle = st_r.test.test_data_toggle;
        st_nxt.test.test_endpoint_speed = st_r.test.test_endpoint_speed;
        st_nxt.test.test_endpoint_format = st_r.test.test_endpoint_format;
      end
      if (bus_req.be[1] != bus_req.be[0])
        st_nxt.test.test_endpoint_address = addr_merge[TST_ADDR_LO +: 11];
    end
    if (wr_cfg && bus_req.addr == OFS_OP_MODE)
    begin
      st_nxt.overlap_off = om_new[OM_OVERLAP_OFF];
      st_nxt.small_buf = om_new[OM_SMALL_BUF];
      st_nxt.buf_bytes = om_new[OM_SMALL_BUF] ? BUF_SMALL_BYTES
                                              : BUF_LARGE_BYTES; // see [RQ5]
    end

    // completion back to the list processor waits for an idle bus only while overlap is off
    st_nxt.completion = partner.engine_status_ready
                        && !(st_r.overlap_off && partner.usb_bus_busy); // see [RQ4]

    st_nxt.irq_int = irq_pending && !st_r.irq_dest; // see [RQ7] see [RQ23]
    st_nxt.irq_smi = irq_pending && st_r.irq_dest; // see [RQ7] see [RQ23]

    // read path: answer every access one cycle later, unmapped reads zero
    st_nxt.rsp.valid = bus_req.valid;
    st_nxt.rsp.rdata = 32'h0000_0000;
    if (rd_any && !bus_req.cfg_space)
    begin
      case (bus_req.addr)
        OFS_REVISION: st_nxt.rsp.rdata = REVISION_VALUE; // see [RQ6]
        OFS_CONTROL: st_nxt.rsp.rdata = ctl_word;
        OFS_CMD_STATUS:
        begin
          st_nxt.rsp.rdata[CMD_TALLY_LO +: 2] = st_r.tally;
          st_nxt.rsp.rdata[CMD_OWNER_REQ] = st_r.owner_req;
          st_nxt.rsp.rdata[CMD_BULK_PEND] = st_r.bulk_pend;
          st_nxt.rsp.rdata[CMD_CTRL_PEND] = st_r.ctrl_pend;
          st_nxt.rsp.rdata[CMD_SOFT_RESET] = st_r.reset_cmd;
        end
        OFS_EVT_STATUS: st_nxt.rsp.rdata = evt_status;
        OFS_EVT_EN_SET: st_nxt.rsp.rdata = evt_enable;
        OFS_EVT_EN_CLR: st_nxt.rsp.rdata = evt_enable;
        default: st_nxt.rsp.rdata = 32'h0000_0000;
      endcase
    end
    else if (rd_any)
    begin
      case (bus_req.addr)
        // write-only test fields never read back
        OFS_TEST_CTRL:
          st_nxt.rsp.rdata[TST_CODE_LO +: 4] = partner.txn_completion_code; // see [RQ1] see [RQ3]
        OFS_OP_MODE: st_nxt.rsp.rdata = {23'h000000, st_r.overlap_off, 7'h00, st_r.small_buf};
        default: st_nxt.rsp.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= '0;
      st_r.hc_state <= STATE_RESET;
      st_r.buf_bytes <= BUF_LARGE_BYTES;
    end
    else
      st_r <= st_nxt;
  end

  assign bus_rsp = st_r.rsp;
  assign test_fields = st_r.test;
  assign ctrl.controller_state_field = st_r.hc_state;
  assign ctrl.bulk_walk_on = st_r.bulk_on; // see [RQ10]
  assign ctrl.ctrl_walk_on = st_r.ctrl_on; // see [RQ10]
  assign ctrl.iso_walk_on = st_r.iso_on; // see [RQ11]
  assign ctrl.periodic_walk_on = st_r.periodic_go; // see [RQ12]
  assign ctrl.ctrl_per_bulk_ratio = st_r.ratio; // see [RQ13]
  assign ctrl.bulk_pending = st_r.bulk_pend;
  assign ctrl.ctrl_pending = st_r.ctrl_pend;
  assign ctrl.engine_overlap_off = st_r.overlap_off;
  assign ctrl.buffer_region_bytes = st_r.buf_bytes;
  assign ctrl.completion_to_lp = st_r.completion;
  assign ctrl.soft_reset_active = st_r.reset_cmd;
  assign ctrl.irq_int = st_r.irq_int;
  assign ctrl.irq_smi = st_r.irq_smi;

  a_revision_read: assert property (@(posedge clk) disable iff (!rst_b)
    rd_any && !bus_req.cfg_space && bus_req.addr == OFS_REVISION
    |=> bus_rsp.valid && bus_rsp.rdata == REVISION_VALUE) else $error("revision wrong"); // see [RQ6]
  a_test_wo_zero: assert property (@(posedge clk) disable iff (!rst_b)
    rd_any && bus_req.cfg_space && bus_req.addr == OFS_TEST_CTRL
    |=> bus_rsp.rdata[15:0] == 16'h0000
        && bus_rsp.rdata[19:16] == $past(partner.txn_completion_code))
    else $error("test register readback wrong"); // see [RQ3]
  a_completion_hold: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.overlap_off && partner.usb_bus_busy |=> !ctrl.completion_to_lp)
    else $error("completion passed during bus activity"); // see [RQ4]
  a_irq_route: assert property (@(posedge clk) disable iff (!rst_b)
    irq_pending && !wr_ctl ##1 !wr_ctl |-> (ctrl.irq_smi == st_r.irq_dest)
      && (ctrl.irq_int != st_r.irq_dest)) else $error("interrupt misrouted"); // see [RQ7]
  a_gate_blocks: assert property (@(posedge clk) disable iff (!rst_b)
    !evt_enable[EV_GATE] |=> !ctrl.irq_int && !ctrl.irq_smi)
    else $error("interrupt without global gate"); // see [RQ22]
  a_resume_force: assert property (@(posedge clk) disable iff (!rst_b)
    st_r.hc_state == STATE_SUSPEND && partner.resume_seen && !wr_ctl && !seq_done
    |=> st_r.hc_state == STATE_RESUME) else $error("resume not taken"); // see [RQ9]
  a_tally_step: assert property (@(posedge clk) disable iff (!rst_b)
    partner.schedule_overrun |=> st_r.tally == $past(st_r.tally) + 2'b01)
    else $error("overrun tally wrong"); // see [RQ14]
  a_owner_event: assert property (@(posedge clk) disable iff (!rst_b)
    wr_cmd && wmasked[CMD_OWNER_REQ] |=> evt_status[EV_OWNER])
    else $error("owner swap not flagged"); // see [RQ15]
  a_pend_clear: assert property (@(posedge clk) disable iff (!rst_b)
    partner.ctrl_head_begin && !partner.ctrl_fill_set && !wr_cmd
    |=> !st_r.ctrl_pend) else $error("control pending not cleared"); // see [RQ16]
  a_reset_selfclr: assert property (@(posedge clk) disable iff (!rst_b)
    seq_start |=> st_r.reset_cmd ##[1:300] !st_r.reset_cmd)
    else $error("soft reset did not clear"); // see [RQ17]
  a_busy_holds_cmd: assert property (@(posedge clk) disable iff (!rst_b) // see [RQ17]
    seq_busy |-> st_r.reset_cmd) else $error("soft reset bit dropped early");
  a_wrap_event: assert property (@(posedge clk) disable iff (!rst_b)
    partner.frame_counter_msb != st_r.frame_msb_q |=> evt_status[EV_WRAP])
    else $error("frame wrap not flagged"); // see [RQ19]

  c_irq_int: cover property (@(posedge clk) disable iff (!rst_b) $rose(ctrl.irq_int));
  c_irq_smi: cover property (@(posedge clk) disable iff (!rst_b) $rose(ctrl.irq_smi));
  c_reset_done: cover property (@(posedge clk) disable iff (!rst_b) seq_done);
  c_tally_wrap: cover property (@(posedge clk) disable iff (!rst_b)
    partner.schedule_overrun && st_r.tally == 2'b11);

endmodule : usb_host_op_regs

// >>> verification/usb_host_op_regs_tb.sv
`timescale 1ns/1ps
module usb_host_op_regs_tb;
  import usb_regs_pkg::*;
  logic clk;
  logic rst_b;
  bus_req_s req;
  bus_rsp_s rsp;
  logic [15:0] pv;
  ctrl_out_s c;
  test_fields_s tf;
  logic [31:0] rd;
  int n_fail;
  int n_tests;

  // partner bits: code 15:12, frame msb 11, hub 10, resume 9, sof 8, done 7, overrun 6,
  // bulk head 5, ctrl head 4, bulk fill 3, ctrl fill 2, ready 1, bus busy 0
  usb_host_op_regs #(.RESET_CYCLES(2)) DUT (.clk(clk), .rst_b(rst_b), .bus_req(req),
    .bus_rsp(rsp), .partner(partner_in_s'(pv)), .ctrl(c), .test_fields(tf));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask : chk

  task automatic acc(input logic w, input logic cf, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 req = '{1'b1, w, cf, a, d, 4'hF};
    @(posedge clk);
    #1 req.valid = 1'b0;
    rd = rsp.rdata;
    chk("rsp_valid", {31'h0, rsp.valid}, 32'h1);
  endtask : acc

  task automatic rdchk(input logic cf, input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, cf, a, 32'h0);
    chk("read", rd, e);
  endtask : rdchk

  task automatic pulse(input logic [15:0] m);
    @(posedge clk);
    #1 pv = pv | m;
    @(posedge clk);
    #1 pv = pv & ~m;
  endtask : pulse

  task automatic t_rev;
    chk("state_rst", {30'h0, c.controller_state_field}, 32'h0);
    chk("buf_rst", {26'h0, c.buffer_region_bytes}, 32'h20);
    acc(1'b1, 1'b0, OFS_REVISION, 32'hFFFF_FFFF);
    rdchk(1'b0, OFS_REVISION, 32'h0000_0110);
    rdchk(1'b0, 8'h18, 32'h0);
  endtask : t_rev

  task automatic t_ctrl_irq;
    acc(1'b1, 1'b0, OFS_CONTROL, 32'hFFFF_FFBF);
    rdchk(1'b0, OFS_CONTROL, 32'h0000_01BF);
    chk("ratio", {30'h0, c.ctrl_per_bulk_ratio}, 32'h3);
    chk("walks", {29'h0, c.bulk_walk_on, c.ctrl_walk_on, c.iso_walk_on}, 32'h7);
    chk("periodic_pre", {31'h0, c.periodic_walk_on}, 32'h0);
    pulse(16'h0100);
    @(posedge clk);
    #1 chk("periodic", {31'h0, c.periodic_walk_on}, 32'h1);
    chk("irq_off", {30'h0, c.irq_smi, c.irq_int}, 32'h0);
    acc(1'b1, 1'b0, OFS_EVT_EN_SET, 32'hFFFF_FFFF);
    rdchk(1'b0, OFS_EVT_EN_SET, 32'hC000_006F);
    chk("irq_smi", {30'h0, c.irq_smi, c.irq_int}, 32'h2);
    acc(1'b1, 1'b0, OFS_EVT_EN_CLR, 32'h8000_0000);
    rdchk(1'b0, OFS_EVT_EN_CLR, 32'h4000_006F);
    chk("irq_gated", {30'h0, c.irq_smi, c.irq_int}, 32'h0);
  endtask : t_ctrl_irq

  task automatic t_events;
    acc(1'b1, 1'b0, OFS_EVT_STATUS, 32'hFFFF_FFFF);
    @(posedge clk);
    #1 pv[11] = 1'b1;
    pulse(16'h07C0);
    rdchk(1'b0, OFS_EVT_STATUS, 32'h0000_006F);
    acc(1'b1, 1'b0, OFS_EVT_STATUS, 32'h0000_0010);
    rdchk(1'b0, OFS_EVT_STATUS, 32'h0000_006F);
    acc(1'b1, 1'b0, OFS_EVT_STATUS, 32'h0000_0004);
    rdchk(1'b0, OFS_EVT_STATUS, 32'h0000_006B);
  endtask : t_events

  task automatic t_cmd;
    // tally already counted the overrun seen in t_events
    for (int k = 2; k <= 4; k++)
    begin
      pulse(16'h0040);
      rdchk(1'b0, OFS_CMD_STATUS, 32'(k % 4) << 16);
    end
    acc(1'b1, 1'b0, OFS_CMD_STATUS, 32'h0000_0008);
    acc(1'b0, 1'b0, OFS_EVT_STATUS, 32'h0);
    chk("owner", rd & 32'h4000_0000, 32'h4000_0000);
    acc(1'b1, 1'b0, OFS_CMD_STATUS, 32'h0000_0006);
    rdchk(1'b0, OFS_CMD_STATUS, 32'h0000_0006);
    pulse(16'h0020);
    rdchk(1'b0, OFS_CMD_STATUS, 32'h0000_0002);
    chk("pend", {30'h0, c.bulk_pending, c.ctrl_pending}, 32'h1);
  endtask : t_cmd

  task automatic t_test_op;
    pv[15:12] = 4'hA;
    acc(1'b1, 1'b1, OFS_TEST_CTRL, 32'hFFF0_A5C3);
    rdchk(1'b1, OFS_TEST_CTRL, 32'h000A_0000);
    chk("test_fields", {16'h0, tf}, 32'h0000_A5C3);
    acc(1'b1, 1'b1, OFS_OP_MODE, 32'hFFFF_FFFF);
    rdchk(1'b1, OFS_OP_MODE, 32'h0000_0101);
    chk("buf16", {26'h0, c.buffer_region_bytes}, 32'h10);
    chk("overlap", {31'h0, c.engine_overlap_off}, 32'h1);
    pv[1:0] = 2'b11;
    repeat (2) @(posedge clk);
    #1 chk("held", {31'h0, c.completion_to_lp}, 32'h0);
    pv[0] = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("released", {31'h0, c.completion_to_lp}, 32'h1);
  endtask : t_test_op

  task automatic t_resume_reset;
    acc(1'b1, 1'b0, OFS_CONTROL, 32'h0000_00C0);
    pulse(16'h0200);
    chk("resume", {30'h0, c.controller_state_field}, 32'h1);
    // gate back on with routing cleared: pending status must reach the normal line
    acc(1'b1, 1'b0, OFS_EVT_EN_SET, 32'h8000_0000);
    @(posedge clk);
    #1 chk("irq_int", {30'h0, c.irq_smi, c.irq_int}, 32'h1);
    acc(1'b1, 1'b0, OFS_CMD_STATUS, 32'h0000_0001);
    chk("srst_on", {31'h0, c.soft_reset_active}, 32'h1);
    // bounded: a stuck reset must not hang the run
    for (int i = 0; i < 40 && c.soft_reset_active !== 1'b0; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("srst_off", {31'h0, c.soft_reset_active}, 32'h0);
    chk("state", {30'h0, c.controller_state_field}, 32'h3);
  endtask : t_resume_reset

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out();
  end

  initial
  begin
    rst_b = 1'b0;
    req = '0;
    pv = 16'h0;
    rd = 32'h0;
    n_fail = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    t_rev();
    t_ctrl_irq();
    t_events();
    t_cmd();
    t_test_op();
    t_resume_reset();
    close_out();
  end
endmodule : usb_host_op_regs_tb
